// ---- verilog/dual_dac_spi_command_decoder.sv ----
// Serial command decoder and chain shift path for a dual 8-bit converter
//
// What this block does
// - Output bit appears 16.5 clocks later, falling edge
// - Serial lines ignored while select is high
// - Load value into all four registers
// - Load value into channel A both registers
// - Load value into channel B both registers
// - Load value into both input registers only
// - Load value into channel A input only
// - Load value into channel B input only
// - Copy both inputs to outputs together
// - Copy single channel input to output
// - Choose internal or external reference, external default
// - Shut down both, A, or B
// - Power up both, A, or B
// - Channel A range six steps, lowest default
// - Channel B range six steps, lowest default
// - Sixteen-bit frame: command, value, zero sub-bits
// - Execute on select rising, then go idle
// - Commands still work during shutdown
`timescale 1ns/1ps
module dual_dac_spi_command_decoder
  import dac_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output dac_cmd_pkg::value_t input_a,
  output dac_cmd_pkg::value_t input_b,
  output dac_cmd_pkg::value_t channel_a_converter,
  output dac_cmd_pkg::value_t channel_b_converter,
  output logic ref_internal,
  output logic shutdown_a,
  output logic shutdown_b,
  output dac_cmd_pkg::range_t range_a,
  output dac_cmd_pkg::range_t range_b
);

  import dac_cmd_pkg::*;

  pin_sync_if lk ();

  dec_state_t st_r;
  dec_state_t st_nxt;
  cmd_t command_field;
  value_t value_field;
  logic exec;
  logic range_a_cmd;
  logic range_b_cmd;

  serial_pin_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sclk(sclk),
    .din(din),
    .lk(lk)
  );

  // Frame fields from the last sixteen bits shifted in
  assign command_field = st_r.sr[CMD_MSB:CMD_LSB];
  assign value_field = st_r.sr[VAL_MSB:VAL_LSB];
  assign exec = lk.frame_end && (st_r.cnt == FRAME_FULL);
  assign range_a_cmd = (command_field[5:3] == RANGE_A_GROUP)
    && (command_field[2:0] <= RANGE_MAX);
  assign range_b_cmd = (command_field[5:3] == RANGE_B_GROUP)
    && (command_field[2:0] <= RANGE_MAX);

  // Shift, chain output and command execution
  always_comb
  begin
    st_nxt = st_r;
    // Rises only arrive while select is low
    if (lk.sclk_rise)
    begin
      st_nxt.sr = {st_r.sr[CHAIN_BITS-2:0], lk.din_bit};
      if (st_r.cnt != FRAME_FULL)
        st_nxt.cnt = st_r.cnt + 5'h01;
    end
    // Extra stage plus falling edge gives the half-cycle offset
    if (lk.sclk_fall)
      st_nxt.dout = st_r.sr[CHAIN_BITS-1];
    if (lk.frame_end)
      st_nxt.cnt = 5'h00;
    // Shutdown state does not gate any command
    if (exec)
    begin
      if (range_a_cmd)
        st_nxt.rng_a = command_field[2:0];
      else if (range_b_cmd)
        st_nxt.rng_b = command_field[2:0];
      else
      begin
        case (command_field)
          CMD_LOAD_BOTH:
          begin
            st_nxt.in_a = value_field;
            st_nxt.in_b = value_field;
            st_nxt.out_a = value_field;
            st_nxt.out_b = value_field;
          end
          CMD_LOAD_A:
          begin
            st_nxt.in_a = value_field;
            st_nxt.out_a = value_field;
          end
          CMD_LOAD_B:
          begin
            st_nxt.in_b = value_field;
            st_nxt.out_b = value_field;
          end
          CMD_IN_BOTH:
          begin
            st_nxt.in_a = value_field;
            st_nxt.in_b = value_field;
          end
          CMD_IN_A: st_nxt.in_a = value_field;
          CMD_IN_B: st_nxt.in_b = value_field;
          CMD_UPD_BOTH:
          begin
            st_nxt.out_a = st_r.in_a;
            st_nxt.out_b = st_r.in_b;
          end
          CMD_UPD_A: st_nxt.out_a = st_r.in_a;
          CMD_UPD_B: st_nxt.out_b = st_r.in_b;
          CMD_REF_INT: st_nxt.ref_int = 1'b1;
          CMD_REF_EXT: st_nxt.ref_int = 1'b0;
          CMD_SHDN_BOTH:
          begin
            st_nxt.shdn_a = 1'b1;
            st_nxt.shdn_b = 1'b1;
          end
          CMD_SHDN_A: st_nxt.shdn_a = 1'b1;
          CMD_SHDN_B: st_nxt.shdn_b = 1'b1;
          CMD_PWR_BOTH:
          begin
            st_nxt.shdn_a = 1'b0;
            st_nxt.shdn_b = 1'b0;
          end
          CMD_PWR_A: st_nxt.shdn_a = 1'b0;
          CMD_PWR_B: st_nxt.shdn_b = 1'b0;
          default: st_nxt.sr = st_r.sr;
        endcase
      end
    end
  end

  // State register; reset gives power-up defaults
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= DEC_RESET;
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign dout = st_r.dout;
  assign input_a = st_r.in_a;
  assign input_b = st_r.in_b;
  assign channel_a_converter = st_r.out_a;
  assign channel_b_converter = st_r.out_b;
  assign ref_internal = st_r.ref_int;
  assign shutdown_a = st_r.shdn_a;
  assign shutdown_b = st_r.shdn_b;
  assign range_a = st_r.rng_a;
  assign range_b = st_r.rng_b;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_exec(cmd_t c);
    exec && (command_field == c);
  endsequence

  sequence s_idle_line;
    !lk.cs_active && !lk.frame_end;
  endsequence

  chk_cs_ignore: assert property (
    s_idle_line |=> $stable(st_r.sr) && $stable(st_r.dout))
    else $error("serial state moved while select high");

  chk_dout_delay: assert property (
    lk.sclk_fall |=> st_r.dout == $past(st_r.sr[CHAIN_BITS-1]))
    else $error("chain output not taken from last stage");

  chk_load_both: assert property (
    s_exec(CMD_LOAD_BOTH) |=> st_r.in_a == $past(value_field)
      && st_r.in_b == $past(value_field)
      && st_r.out_a == $past(value_field)
      && st_r.out_b == $past(value_field))
    else $error("load both failed");

  chk_load_a: assert property (
    s_exec(CMD_LOAD_A) |=> st_r.out_a == $past(value_field)
      && st_r.in_a == $past(value_field)
      && $stable(st_r.in_b) && $stable(st_r.out_b))
    else $error("load A failed");

  chk_load_b: assert property (
    s_exec(CMD_LOAD_B) |=> st_r.out_b == $past(value_field)
      && st_r.in_b == $past(value_field)
      && $stable(st_r.in_a) && $stable(st_r.out_a))
    else $error("load B failed");

  chk_input_both: assert property (
    s_exec(CMD_IN_BOTH) |=> st_r.in_a == $past(value_field)
      && st_r.in_b == $past(value_field)
      && $stable(st_r.out_a) && $stable(st_r.out_b))
    else $error("input-only load touched outputs");

  chk_input_a: assert property (
    s_exec(CMD_IN_A) |=> st_r.in_a == $past(value_field)
      && $stable(st_r.out_a) && $stable(st_r.in_b))
    else $error("input A load failed");

  chk_input_b: assert property (
    s_exec(CMD_IN_B) |=> st_r.in_b == $past(value_field)
      && $stable(st_r.out_b) && $stable(st_r.in_a))
    else $error("input B load failed");

  chk_update_both: assert property (
    s_exec(CMD_UPD_BOTH) |=> st_r.out_a == $past(st_r.in_a)
      && st_r.out_b == $past(st_r.in_b))
    else $error("update both failed");

  chk_update_a: assert property (
    s_exec(CMD_UPD_A) |=> st_r.out_a == $past(st_r.in_a)
      && $stable(st_r.out_b))
    else $error("update A failed");

  chk_ref_mode: assert property (
    s_exec(CMD_REF_INT) ##1 !exec[*2] |-> st_r.ref_int)
    else $error("internal reference not held");

  chk_shutdown_both: assert property (
    s_exec(CMD_SHDN_BOTH) |=> st_r.shdn_a && st_r.shdn_b)
    else $error("shutdown both failed");

  chk_power_both: assert property (
    s_exec(CMD_PWR_BOTH) |=> !st_r.shdn_a && !st_r.shdn_b)
    else $error("power up both failed");

  chk_range_a: assert property (
    exec && range_a_cmd |=> st_r.rng_a == $past(command_field[2:0])
      && $stable(st_r.rng_b))
    else $error("range A select failed");

  chk_range_b: assert property (
    exec && range_b_cmd |=> st_r.rng_b == $past(command_field[2:0])
      && $stable(st_r.rng_a))
    else $error("range B select failed");

  chk_short_frame: assert property (
    lk.frame_end && st_r.cnt != FRAME_FULL |=> $stable(st_r.out_a)
      && $stable(st_r.in_a) && $stable(st_r.shdn_a))
    else $error("short frame executed");

  chk_mode_hold: assert property (
    !exec |=> $stable(st_r.ref_int) && $stable(st_r.shdn_a)
      && $stable(st_r.shdn_b) && $stable(st_r.rng_a)
      && $stable(st_r.rng_b) && $stable(st_r.out_a))
    else $error("mode changed without command");

  chk_nop_code: assert property (
    s_exec(CMD_NOP) |=> $stable(st_r.in_a) && $stable(st_r.in_b)
      && $stable(st_r.out_a) && $stable(st_r.out_b)
      && $stable(st_r.ref_int) && $stable(st_r.rng_a))
    else $error("no-op changed state");

endmodule

// ---- verilog/dac_cmd_pkg.sv ----
// Shared constants and state types for the dual converter command decoder
package dac_cmd_pkg;

  // Frame layout: command, value, two sub-bits, MSB first
  localparam int FRAME_BITS = 16;
  localparam int CHAIN_BITS = FRAME_BITS + 1;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 10;
  localparam int VAL_MSB = 9;
  localparam int VAL_LSB = 2;
  localparam logic [4:0] FRAME_FULL = 5'h10;

  typedef logic [5:0] cmd_t;
  typedef logic [7:0] value_t;
  typedef logic [2:0] range_t;

  // Command codes
  localparam cmd_t CMD_NOP = 6'h00;
  localparam cmd_t CMD_LOAD_BOTH = 6'h01;
  localparam cmd_t CMD_LOAD_A = 6'h02;
  localparam cmd_t CMD_LOAD_B = 6'h03;
  localparam cmd_t CMD_IN_BOTH = 6'h04;
  localparam cmd_t CMD_IN_A = 6'h05;
  localparam cmd_t CMD_IN_B = 6'h06;
  localparam cmd_t CMD_UPD_BOTH = 6'h07;
  localparam cmd_t CMD_UPD_A = 6'h09;
  localparam cmd_t CMD_UPD_B = 6'h0a;
  localparam cmd_t CMD_REF_INT = 6'h0b;
  localparam cmd_t CMD_REF_EXT = 6'h0c;
  localparam cmd_t CMD_SHDN_BOTH = 6'h0d;
  localparam cmd_t CMD_SHDN_A = 6'h0e;
  localparam cmd_t CMD_SHDN_B = 6'h0f;
  localparam cmd_t CMD_PWR_BOTH = 6'h2d;
  localparam cmd_t CMD_PWR_A = 6'h2e;
  localparam cmd_t CMD_PWR_B = 6'h2f;

  // Range commands: group in upper three bits, range index in lower three
  localparam logic [2:0] RANGE_A_GROUP = 3'h2;
  localparam logic [2:0] RANGE_B_GROUP = 3'h6;
  localparam range_t RANGE_MAX = 3'h5;
  localparam range_t RANGE_LOWEST = 3'h0;

  // Pin synchroniser state
  typedef struct packed {
    logic [1:0] cs_n_ff;
    logic [1:0] sclk_ff;
    logic [1:0] din_ff;
    logic sclk_q;
    logic cs_q;
  } sync_state_t;

  localparam sync_state_t SYNC_RESET = '{cs_n_ff: 2'h3, sclk_ff: 2'h0,
    din_ff: 2'h0, sclk_q: 1'b0, cs_q: 1'b1};

  // Decoder state
  typedef struct packed {
    logic [CHAIN_BITS-1:0] sr;
    logic [4:0] cnt;
    logic dout;
    value_t in_a;
    value_t in_b;
    value_t out_a;
    value_t out_b;
    logic ref_int;
    logic shdn_a;
    logic shdn_b;
    range_t rng_a;
    range_t rng_b;
  } dec_state_t;

  localparam dec_state_t DEC_RESET = '{sr: 17'h0_0000, cnt: 5'h00,
    dout: 1'b0, in_a: 8'h00, in_b: 8'h00, out_a: 8'h00, out_b: 8'h00,
    ref_int: 1'b0, shdn_a: 1'b0, shdn_b: 1'b0, rng_a: RANGE_LOWEST,
    rng_b: RANGE_LOWEST};

endpackage

// ---- verilog/pin_sync_if.sv ----
// Synchronised serial pin events passed from the pin stage to the decoder
`timescale 1ns/1ps
interface pin_sync_if;
  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic din_bit;
  logic frame_end;

  modport src (output cs_active, sclk_rise, sclk_fall, din_bit, frame_end);
  modport dst (input cs_active, sclk_rise, sclk_fall, din_bit, frame_end);
endinterface

// ---- verilog/serial_pin_sync.sv ----
// Two-stage pin synchroniser and serial clock edge finder
`timescale 1ns/1ps
module serial_pin_sync
  import dac_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  pin_sync_if.src lk
);

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Shift pins through two stages, keep one delayed copy for edges
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cs_n_ff = {s_r.cs_n_ff[0], cs_n};
    s_nxt.sclk_ff = {s_r.sclk_ff[0], sclk};
    s_nxt.din_ff = {s_r.din_ff[0], din};
    s_nxt.sclk_q = s_r.sclk_ff[1];
    s_nxt.cs_q = s_r.cs_n_ff[1];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_r <= SYNC_RESET;
    else
      s_r <= s_nxt;
  end

  // Edges only count while the select is low
  assign lk.cs_active = !s_r.cs_n_ff[1];
  assign lk.sclk_rise = lk.cs_active && s_r.sclk_ff[1] && !s_r.sclk_q;
  assign lk.sclk_fall = lk.cs_active && !s_r.sclk_ff[1] && s_r.sclk_q;
  assign lk.din_bit = s_r.din_ff[1];
  assign lk.frame_end = s_r.cs_n_ff[1] && !s_r.cs_q;

endmodule

// ---- dv/spi_host_model.sv ----
// Host-side serial master model that drives the command link
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic dout,
  output logic cs_n, // Common select for the whole chain
  output logic sclk, // Common link clock, idles low
  output logic din
);
  // Half period of the 160 ns link clock in system cycles
  localparam int HALF = 20;
  logic [31:0] got;

  // Idle levels before any frame
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    got = 32'h0000_0000;
  end

  // One frame, select low throughout, MSB first, chained bits captured
  task automatic send(input logic [31:0] bits, input int n);
    int i;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (i = n - 1; i >= 0; i--)
    begin
      din <= bits[i];
      repeat (HALF) @(posedge clk);
      got <= {got[30:0], dout};
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    got <= {got[30:0], dout};
    cs_n <= 1'b1;
    din <= ~din; // Released line shows no stale bit
    repeat (HALF) @(posedge clk);
  endtask

  // Toggles clock and data while deselected
  task automatic noise(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      sclk <= ~sclk;
      din <= ~din;
      repeat (HALF - 1) @(posedge clk);
    end
  endtask
endmodule

// ---- dv/dual_dac_spi_command_decoder_test.sv ----
// Self-checking bench for the dual converter command decoder
`timescale 1ns/1ps
module dual_dac_spi_command_decoder_test;
  import dac_cmd_pkg::*;
  logic clk;
  logic nrst;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  value_t input_a, input_b, conv_a, conv_b;
  logic ref_internal, shutdown_a, shutdown_b;
  range_t range_a, range_b;
  int mismatches;
  int check_count;
  int i;
  logic d0;

  dual_dac_spi_command_decoder u_dut (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .input_a(input_a), .input_b(input_b),
    .channel_a_converter(conv_a), .channel_b_converter(conv_b),
    .ref_internal(ref_internal), .shutdown_a(shutdown_a),
    .shutdown_b(shutdown_b), .range_a(range_a), .range_b(range_b)
  );

  spi_host_model u_host (
    .clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din)
  );

  // 250 MHz system clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input cmd_t c, input value_t v);
    u_host.send({16'h0000, c, v, 2'b00}, 16);
  endtask

  task automatic regs(input value_t ia, ib, oa, ob);
    check("input_a", input_a, ia);
    check("input_b", input_b, ib);
    check("conv_a", conv_a, oa);
    check("conv_b", conv_b, ob);
  endtask

  task automatic modes(input logic r, sa, sb, input range_t ra, rb);
    check("ref_internal", ref_internal, r);
    check("shutdown_a", shutdown_a, sa);
    check("shutdown_b", shutdown_b, sb);
    check("range_a", range_a, ra);
    check("range_b", range_b, rb);
  endtask

  task automatic t_reset();
    regs(8'h00, 8'h00, 8'h00, 8'h00);
    modes(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
  endtask

  task automatic t_loads();
    cmd(CMD_LOAD_BOTH, 8'ha5);
    regs(8'ha5, 8'ha5, 8'ha5, 8'ha5);
    cmd(CMD_LOAD_A, 8'h3c);
    regs(8'h3c, 8'ha5, 8'h3c, 8'ha5);
    cmd(CMD_LOAD_B, 8'hc3);
    regs(8'h3c, 8'hc3, 8'h3c, 8'hc3);
    cmd(CMD_IN_BOTH, 8'h11);
    regs(8'h11, 8'h11, 8'h3c, 8'hc3);
    cmd(CMD_IN_A, 8'h22);
    regs(8'h22, 8'h11, 8'h3c, 8'hc3);
    cmd(CMD_IN_B, 8'h44);
    regs(8'h22, 8'h44, 8'h3c, 8'hc3);
    cmd(CMD_UPD_A, 8'hff);
    regs(8'h22, 8'h44, 8'h22, 8'hc3);
    cmd(CMD_IN_A, 8'h55);
    cmd(CMD_UPD_B, 8'h00);
    regs(8'h55, 8'h44, 8'h22, 8'h44);
    cmd(CMD_UPD_BOTH, 8'h99);
    regs(8'h55, 8'h44, 8'h55, 8'h44);
  endtask

  task automatic t_modes();
    cmd(CMD_REF_INT, 8'h00);
    modes(1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
    cmd(CMD_SHDN_A, 8'h00);
    modes(1'b1, 1'b1, 1'b0, 3'h0, 3'h0);
    cmd(CMD_SHDN_B, 8'h00);
    modes(1'b1, 1'b1, 1'b1, 3'h0, 3'h0);
    cmd(CMD_LOAD_BOTH, 8'h77);
    regs(8'h77, 8'h77, 8'h77, 8'h77);
    cmd(CMD_PWR_A, 8'h00);
    modes(1'b1, 1'b0, 1'b1, 3'h0, 3'h0);
    cmd(CMD_PWR_B, 8'h00);
    modes(1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
    cmd(CMD_SHDN_BOTH, 8'h00);
    modes(1'b1, 1'b1, 1'b1, 3'h0, 3'h0);
    cmd(CMD_PWR_BOTH, 8'h00);
    modes(1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
    cmd(CMD_REF_EXT, 8'h00);
    modes(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    // Every range code on both channels, opposite directions
    for (i = 0; i < 6; i++)
    begin
      cmd({RANGE_A_GROUP, 3'(5 - i)}, 8'h00);
      cmd({RANGE_B_GROUP, 3'(i)}, 8'h00);
      modes(1'b0, 1'b0, 1'b0, 3'(5 - i), 3'(i));
    end
    // Unassigned codes leave everything alone
    cmd({RANGE_A_GROUP, 3'h6}, 8'h00);
    cmd({RANGE_B_GROUP, 3'h7}, 8'h00);
    cmd(6'h08, 8'h12);
    cmd(CMD_NOP, 8'h34);
    modes(1'b0, 1'b0, 1'b0, 3'h0, 3'h5);
    regs(8'h77, 8'h77, 8'h77, 8'h77);
  endtask

  // Two frames back to back: first passes down the chain
  task automatic t_chain();
    u_host.send({{CMD_LOAD_A, 8'hc8, 2'b00}, {CMD_LOAD_B, 8'h5a, 2'b00}},
      32);
    check("chain", u_host.got[15:0], {CMD_LOAD_A, 8'hc8, 2'b00});
    regs(8'h77, 8'h5a, 8'h77, 8'h5a);
  endtask

  // Activity while deselected and a short frame change nothing
  task automatic t_ignore();
    d0 = dout;
    u_host.noise(16);
    repeat (10) @(posedge clk);
    check("dout_idle", dout, d0);
    regs(8'h77, 8'h5a, 8'h77, 8'h5a);
    u_host.send({16'h0000, CMD_LOAD_BOTH, 8'h01, 2'b00}, 10);
    regs(8'h77, 8'h5a, 8'h77, 8'h5a);
  endtask

  // Reset in mid-run brings back every power-up default
  task automatic t_power_cycle();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    check("dout_reset", dout, 1'b0);
    t_reset();
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_loads();
    t_modes();
    t_chain();
    t_ignore();
    t_power_cycle();
    wrap_up();
  end

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
